// ### verilog/dacwo_map.vh
`ifndef DACWO_MAP_VH
`define DACWO_MAP_VH

// converter code layout
`define DACWO_CODE_W 12
`define DACWO_CH0_LSB 0
`define DACWO_CH1_LSB 12
`define DACWO_WORD_W 24
`define DACWO_ZERO_CODE 12'h800
`define DACWO_FULL_CODE 12'hFFF

// sample store
`define DACWO_FIFO_DEPTH 2048
`define DACWO_FIFO_AW 11
`define DACWO_HALF_DEPTH 1024

// conversion clock select
`define DACWO_SEL_SW 2'h0
`define DACWO_SEL_INT 2'h1
`define DACWO_SEL_EXT 2'h2

// playback modes
`define DACWO_PLAY_SHOT 2'h0
`define DACWO_PLAY_CONT 2'h1
`define DACWO_PLAY_REGEN 2'h2

// divisor width
`define DACWO_DIV_W 24

`endif

// ### verilog/dacwo_sample_mem.v
`timescale 1ns/1ps
`default_nettype none

module dacwo_sample_mem #(
  parameter AW = 11,
  parameter DW = 24
) (
  input wire clk,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [DW-1:0] wr_data,
  input wire rd_en,
  input wire [AW-1:0] rd_addr,
  output reg [DW-1:0] rd_data
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  // one write port, one registered read port
  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule // dacwo_sample_mem

`default_nettype wire

// ### verilog/dacwo_skid.v
`timescale 1ns/1ps
`default_nettype none

module dacwo_skid #(
  parameter DW = 24
) (
  input wire clk,
  input wire nrst,
  input wire flush,
  input wire in_valid,
  input wire [DW-1:0] in_data,
  output wire in_ready,
  output wire out_valid,
  output wire [DW-1:0] out_data,
  input wire out_ready
);

  reg [DW-1:0] ent0_reg;
  reg [DW-1:0] ent1_reg;
  reg [1:0] cnt_reg;

  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  // two entries: a stall on the drain side never drops a word
  assign in_ready = (cnt_reg != 2'h2);
  assign out_valid = (cnt_reg != 2'h0);
  assign out_data = ent0_reg;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= 2'h0;
      ent0_reg <= {DW{1'b0}};
      ent1_reg <= {DW{1'b0}};
    end else if (flush) begin
      cnt_reg <= 2'h0;
    end else begin
      case ({push, pop})
        2'b10: begin
          if (cnt_reg == 2'h0) ent0_reg <= in_data;
          else ent1_reg <= in_data;
          cnt_reg <= cnt_reg + 2'h1;
        end
        2'b01: begin
          ent0_reg <= ent1_reg;
          cnt_reg <= cnt_reg - 2'h1;
        end
        2'b11: begin
          // shift and refill in the same cycle
          if (cnt_reg == 2'h1) ent0_reg <= in_data;
          else begin
            ent0_reg <= ent1_reg;
            ent1_reg <= in_data;
          end
        end
        default: begin
          cnt_reg <= cnt_reg;
        end
      endcase
    end
  end

endmodule // dacwo_skid

`default_nettype wire

// ### verilog/dacwo_top.v
// How it works
// - two channels, each a 12-bit output register
// - single write loads code, held until rewritten
// - word bits 11:0 ch0, 23:12 ch1
// - straight binary, 0 negative, FFF positive
// - buffered mode loads both channels together
// - each conversion pops next word to outputs
// - conversion source: strobe, 11/33 MHz, external
// - internal rate is base over divisor plus one
// - external line starts/stops internal-clock conversions
// - external start also starts analog input block
// - buffered, not regenerating: below half full raise refill request
// - empty store keeps last codes presented
// - regeneration replays store from first sample
// - single shot plays once then stops
// - subsystem reset clears state, outputs zero volts
`timescale 1ns/1ps
`include "dacwo_map.vh"
`default_nettype none

module dacwo_top #(
  parameter AW = `DACWO_FIFO_AW,
  parameter DEPTH = `DACWO_FIFO_DEPTH,
  parameter DIV_W = `DACWO_DIV_W
) (
  input wire clk,
  input wire nrst,
  input wire sub_reset,
  input wire mode_buffered,
  input wire single_wr0,
  input wire [11:0] single_code0,
  input wire single_wr1,
  input wire [11:0] single_code1,
  input wire fill_valid,
  input wire [31:0] fill_data,
  output wire fill_ready,
  input wire [1:0] internal_conversion_clock_select,
  input wire base_sel_33,
  input wire base_tick_11,
  input wire base_tick_33,
  input wire [DIV_W-1:0] divisor,
  input wire sw_conv_strobe,
  input wire ext_trig,
  input wire ext_start_en,
  input wire ext_stop_en,
  input wire sw_start,
  input wire sw_stop,
  input wire conv_enable,
  input wire [1:0] play_mode,
  input wire flags_clear,
  output reg [11:0] dac0_code_reg,
  output reg [11:0] dac1_code_reg,
  output wire running,
  output wire refill_req,
  output reg waveform_complete_flag,
  output reg underrun_flag,
  output reg ai_sync_start,
  output wire irq
);

  localparam ST_IDLE = 2'b01;
  localparam ST_RUN = 2'b10;
  localparam [AW:0] DEPTH_P = DEPTH;
  // half of the store, so a shrunken store still asks in time
  localparam [AW:0] HALF_P = DEPTH_P >> 1;

  reg [1:0] state_reg;
  reg [1:0] ext_sync_reg;
  reg ext_prev_reg;
  reg [DIV_W-1:0] div_cnt_reg;
  reg [AW:0] wr_ptr_reg;
  reg [AW:0] rd_ptr_reg;
  reg [AW:0] base_ptr_reg;
  reg load_pend_reg;

  // external line: two flops before anything looks at it
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ext_sync_reg <= 2'h0;
      ext_prev_reg <= 1'b0;
    end else begin
      ext_sync_reg <= {ext_sync_reg[0], ext_trig};
      ext_prev_reg <= ext_sync_reg[1];
    end
  end

  wire ext_rise = ext_sync_reg[1] & ~ext_prev_reg;
  wire run_st = (state_reg == ST_RUN);
  assign running = run_st;

  // edge role depends on the clock source: trigger or conversion
  wire sel_int = (internal_conversion_clock_select == `DACWO_SEL_INT);
  wire ext_start = sel_int & ext_start_en & ext_rise & ~run_st;
  wire ext_stop = sel_int & ext_stop_en & ext_rise & run_st;

  // sample path through the two-entry buffer
  wire sk_valid;
  wire [`DACWO_WORD_W-1:0] sk_data;
  wire [AW:0] stored = wr_ptr_reg - base_ptr_reg;
  wire [AW:0] pending = wr_ptr_reg - rd_ptr_reg;
  wire store_full = (stored == DEPTH_P);
  wire sk_ready = ~store_full & ~sub_reset;
  wire wr_fire = sk_valid & sk_ready;

  dacwo_skid #(.DW(`DACWO_WORD_W)) u_skid (
    .clk(clk),
    .nrst(nrst),
    .flush(sub_reset),
    .in_valid(fill_valid),
    .in_data(fill_data[`DACWO_WORD_W-1:0]),
    .in_ready(fill_ready),
    .out_valid(sk_valid),
    .out_data(sk_data),
    .out_ready(sk_ready)
  );

  // base rate divider; restarts whenever output is stopped
  wire base_tick = base_sel_33 ? base_tick_33 : base_tick_11;
  wire div_done = base_tick & (div_cnt_reg == divisor);

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_cnt_reg <= {DIV_W{1'b0}};
    end else if (!run_st || sub_reset || div_done) begin
      div_cnt_reg <= {DIV_W{1'b0}};
    end else if (base_tick) begin
      div_cnt_reg <= div_cnt_reg + {{(DIV_W-1){1'b0}}, 1'b1};
    end
  end

  // conversion pulse from the selected source
  reg src_pulse;
  always @* begin
    case (internal_conversion_clock_select)
      `DACWO_SEL_SW: src_pulse = sw_conv_strobe;
      `DACWO_SEL_INT: src_pulse = div_done;
      `DACWO_SEL_EXT: src_pulse = ext_rise;
      default: src_pulse = 1'b0;
    endcase
  end

  wire conv = run_st & conv_enable & mode_buffered & src_pulse;
  wire regen = (play_mode == `DACWO_PLAY_REGEN);
  wire shot = (play_mode == `DACWO_PLAY_SHOT);
  wire avail = (pending != {(AW+1){1'b0}});
  wire can_wrap = regen & ~avail & (stored != {(AW+1){1'b0}});
  wire pop_now = conv & avail;
  wire wrap_now = conv & can_wrap;
  wire last_pop = pop_now & shot & (pending == {{AW{1'b0}}, 1'b1});
  wire starved = conv & ~avail & ~can_wrap;

  // read address: next sample, or first stored sample on a wrap
  wire rd_en = pop_now | wrap_now;
  wire [AW-1:0] rd_addr = pop_now ? rd_ptr_reg[AW-1:0]
                                  : base_ptr_reg[AW-1:0];
  wire [`DACWO_WORD_W-1:0] rd_data;

  dacwo_sample_mem #(.AW(AW), .DW(`DACWO_WORD_W)) u_mem (
    .clk(clk),
    .wr_en(wr_fire),
    .wr_addr(wr_ptr_reg[AW-1:0]),
    .wr_data(sk_data),
    .rd_en(rd_en),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  // pointers; regeneration keeps played words, others free them
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_reg <= {(AW+1){1'b0}};
      rd_ptr_reg <= {(AW+1){1'b0}};
      base_ptr_reg <= {(AW+1){1'b0}};
      load_pend_reg <= 1'b0;
    end else if (sub_reset) begin
      wr_ptr_reg <= {(AW+1){1'b0}};
      rd_ptr_reg <= {(AW+1){1'b0}};
      base_ptr_reg <= {(AW+1){1'b0}};
      load_pend_reg <= 1'b0;
    end else begin
      load_pend_reg <= rd_en;
      if (wr_fire) begin
        wr_ptr_reg <= wr_ptr_reg + {{AW{1'b0}}, 1'b1};
      end
      if (pop_now) begin
        rd_ptr_reg <= rd_ptr_reg + {{AW{1'b0}}, 1'b1};
        if (!regen) begin
          base_ptr_reg <= rd_ptr_reg + {{AW{1'b0}}, 1'b1};
        end
      end else if (wrap_now) begin
        rd_ptr_reg <= base_ptr_reg + {{AW{1'b0}}, 1'b1};
      end
    end
  end

  // output registers; an empty store simply leaves them alone
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dac0_code_reg <= `DACWO_ZERO_CODE;
      dac1_code_reg <= `DACWO_ZERO_CODE;
    end else if (sub_reset) begin
      dac0_code_reg <= `DACWO_ZERO_CODE;
      dac1_code_reg <= `DACWO_ZERO_CODE;
    end else if (mode_buffered) begin
      if (load_pend_reg) begin
        // both channels from one word in the same edge
        dac0_code_reg <= rd_data[`DACWO_CH0_LSB +: 12];
        dac1_code_reg <= rd_data[`DACWO_CH1_LSB +: 12];
      end
    end else begin
      if (single_wr0) begin
        dac0_code_reg <= single_code0;
      end
      if (single_wr1) begin
        dac1_code_reg <= single_code1;
      end
    end
  end

  // run control; in idle a start is taken even with a stop in the same cycle
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
      ai_sync_start <= 1'b0;
    end else begin
      ai_sync_start <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (!sub_reset && (sw_start || ext_start)) begin
            state_reg <= ST_RUN;
            ai_sync_start <= ext_start;
          end
        end
        ST_RUN: begin
          if (sub_reset || sw_stop || ext_stop || last_pop) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // sticky event flags; a new event beats a clear
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      waveform_complete_flag <= 1'b0;
      underrun_flag <= 1'b0;
    end else if (sub_reset) begin
      waveform_complete_flag <= 1'b0;
      underrun_flag <= 1'b0;
    end else begin
      if (last_pop) waveform_complete_flag <= 1'b1;
      else if (flags_clear) waveform_complete_flag <= 1'b0;
      if (starved) underrun_flag <= 1'b1;
      else if (flags_clear) underrun_flag <= 1'b0;
    end
  end

  // refill wanted only while streaming fresh data
  assign refill_req = mode_buffered & ~regen & (pending < HALF_P);
  assign irq = refill_req | waveform_complete_flag | underrun_flag;

endmodule // dacwo_top

`default_nettype wire

// ### test/dacwo_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "dacwo_map.vh"
module dacwo_props (
  input wire clk,
  input wire nrst,
  input wire sub_reset,
  input wire mode_buffered,
  input wire single_wr0,
  input wire [11:0] single_code0,
  input wire single_wr1,
  input wire sw_start,
  input wire sw_stop,
  input wire [1:0] play_mode,
  input wire flags_clear,
  input wire [11:0] dac0_code_reg,
  input wire [11:0] dac1_code_reg,
  input wire running,
  input wire refill_req,
  input wire waveform_complete_flag,
  input wire underrun_flag,
  input wire ai_sync_start,
  input wire irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // nothing may move the codes in this cycle
  sequence s_quiet;
    !sub_reset && !mode_buffered && !single_wr0 && !single_wr1;
  endsequence
  sequence s_start;
    sw_start && !sw_stop && !sub_reset && mode_buffered;
  endsequence
  property p_zero;
    sub_reset |=> dac0_code_reg == `DACWO_ZERO_CODE &&
      dac1_code_reg == `DACWO_ZERO_CODE && !running;
  endproperty
  property p_single;
    !sub_reset && !mode_buffered && single_wr0
      |=> dac0_code_reg == $past(single_code0);
  endproperty
  property p_hold;
    s_quiet |=> $stable({dac1_code_reg, dac0_code_reg});
  endproperty
  property p_start;
    s_start |=> running;
  endproperty
  property p_stop;
    sw_stop && !sw_start && !sub_reset |=> !running;
  endproperty
  property p_irq;
    irq == (refill_req || waveform_complete_flag || underrun_flag);
  endproperty
  property p_sticky;
    underrun_flag && !flags_clear && !sub_reset |=> underrun_flag;
  endproperty
  property p_done;
    $rose(waveform_complete_flag) |-> !running;
  endproperty
  property p_sync;
    ai_sync_start |=> !ai_sync_start;
  endproperty
  // regeneration replays, so it never asks for more words
  property p_regen;
    mode_buffered && play_mode == `DACWO_PLAY_REGEN |-> !refill_req;
  endproperty
  a_zero: assert property (p_zero)
    else $error("codes not midscale after subsystem reset");
  a_single: assert property (p_single)
    else $error("single write not loaded");
  a_hold: assert property (p_hold)
    else $error("codes moved without a write");
  a_start: assert property (p_start)
    else $error("start not taken");
  a_stop: assert property (p_stop)
    else $error("stop not taken");
  a_irq: assert property (p_irq)
    else $error("irq not the or of its sources");
  a_sticky: assert property (p_sticky)
    else $error("underrun flag lost");
  a_done: assert property (p_done)
    else $error("done while still running");
  a_sync: assert property (p_sync)
    else $error("sync start longer than one cycle");
  a_regen: assert property (p_regen)
    else $error("refill asked in regeneration");
endmodule // dacwo_props
`default_nettype wire

// ### test/dacwo_host.sv
`timescale 1ns/1ps
`default_nettype none
module dacwo_host (
  input wire clk,
  input wire fill_ready,
  output logic fill_valid,
  output logic [31:0] fill_data
);
  initial begin
    fill_valid = 1'b0;
    fill_data = 32'h0;
  end
  // one packed word, held until a ready edge takes it
  task automatic send(input logic [23:0] w);
    logic r;
    repeat ($urandom_range(2, 1)) @(posedge clk); // random stall
    #2;
    fill_valid = 1'b1;
    fill_data = {8'($urandom), w};
    r = 1'b0;
    while (!r) begin
      @(negedge clk);
      r = fill_ready;
      @(posedge clk);
    end
    #2;
    fill_valid = 1'b0;
    fill_data = ~fill_data; // stale data must not look valid
  endtask
endmodule // dacwo_host
`default_nettype wire

// ### test/test_dual_dac_waveform_output.sv
`timescale 1ns/1ps
`default_nettype none
`include "dacwo_map.vh"
module test_dual_dac_waveform_output;
  logic clk = 0;
  logic nrst, sub_reset, mode_buffered, single_wr0, single_wr1, base_sel_33;
  logic [11:0] single_code0, single_code1, dac0_code_reg, dac1_code_reg;
  logic [1:0] internal_conversion_clock_select, play_mode;
  logic base_tick_11, base_tick_33, sw_conv_strobe, ext_trig, sw_start;
  logic ext_start_en, ext_stop_en, sw_stop, conv_enable, flags_clear;
  logic fill_valid, fill_ready, running, refill_req, irq, ai_sync_start;
  logic waveform_complete_flag, underrun_flag;
  logic [31:0] fill_data;
  logic [23:0] divisor, prev, ev, w;
  logic [23:0] expq[$];
  logic [23:0] tbl [3] = '{24'h000000, 24'hFFFFFF, 24'h000FFF};
  int mismatches = 0;
  int checked = 0;
  int i;
  always #12.5 clk = ~clk;
  dacwo_top #(.AW(4), .DEPTH(16)) i_dacwo_top (.clk(clk), .nrst(nrst),
    .sub_reset(sub_reset), .mode_buffered(mode_buffered),
    .single_wr0(single_wr0), .single_code0(single_code0),
    .single_wr1(single_wr1), .single_code1(single_code1),
    .fill_valid(fill_valid), .fill_data(fill_data), .fill_ready(fill_ready),
    .internal_conversion_clock_select(internal_conversion_clock_select),
    .base_sel_33(base_sel_33), .base_tick_11(base_tick_11),
    .base_tick_33(base_tick_33), .divisor(divisor),
    .sw_conv_strobe(sw_conv_strobe), .ext_trig(ext_trig),
    .ext_start_en(ext_start_en), .ext_stop_en(ext_stop_en),
    .sw_start(sw_start), .sw_stop(sw_stop), .conv_enable(conv_enable),
    .play_mode(play_mode), .flags_clear(flags_clear),
    .dac0_code_reg(dac0_code_reg), .dac1_code_reg(dac1_code_reg),
    .running(running), .refill_req(refill_req),
    .waveform_complete_flag(waveform_complete_flag),
    .underrun_flag(underrun_flag), .ai_sync_start(ai_sync_start), .irq(irq));
  dacwo_host i_dacwo_host (.clk(clk), .fill_ready(fill_ready),
    .fill_valid(fill_valid), .fill_data(fill_data));
  task chk_w(input string n, input logic [23:0] e, input logic [23:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task chk_b(input string n, input logic e, input logic g);
    chk_w(n, {23'h0, e}, {23'h0, g});
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task put(input logic [23:0] d);
    expq.push_back(d);
    i_dacwo_host.send(d);
  endtask
  // strobe held high: back-to-back conversions
  task strb(input int n);
    sw_conv_strobe = 1;
    tick(n);
    sw_conv_strobe = 0;
  endtask
  task conclude;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // every change of the code pair is one expected load
  always @(posedge clk) begin
    #1;
    if (nrst && {dac1_code_reg, dac0_code_reg} !== prev) begin
      ev = expq.size() ? expq.pop_front() : 24'hx;
      chk_w("codes", ev, {dac1_code_reg, dac0_code_reg});
    end
    prev = {dac1_code_reg, dac0_code_reg};
  end
  // random base ticks so the divider sees uneven spacing
  always @(posedge clk) begin
    #2;
    base_tick_11 = 1'($urandom);
    base_tick_33 = 1'($urandom);
  end
  initial begin
    #200000;
    mismatches++;
    conclude();
  end
  initial begin
    {nrst, sub_reset, mode_buffered, single_wr0, single_wr1} = 0;
    {single_code0, single_code1, internal_conversion_clock_select} = 0;
    {base_sel_33, sw_conv_strobe, ext_trig, ext_start_en, ext_stop_en} = 0;
    {sw_start, sw_stop, flags_clear} = 0;
    divisor = 24'h3;
    conv_enable = 1;
    play_mode = `DACWO_PLAY_CONT;
    w = 24'($urandom(13));
    tick(20);
    nrst = 1;
    for (i = 0; i < 4; i++) begin
      w = (i < 3) ? tbl[i] : 24'($urandom);
      {single_code1, single_code0} = w;
      {single_wr0, single_wr1} = 2'h3;
      expq.push_back(w);
      tick(1);
      {single_wr0, single_wr1} = 0;
      tick(2);
    end
    sub_reset = 1;
    expq.push_back({2{`DACWO_ZERO_CODE}});
    tick(1);
    sub_reset = 0;
    mode_buffered = 1;
    for (i = 0; i < 18; i++) put(24'($urandom));
    tick(3);
    chk_b("fill_ready", 0, fill_ready);
    chk_b("refill_req", 0, refill_req);
    sw_start = 1;
    tick(1);
    sw_start = 0;
    strb(18);
    tick(4);
    chk_b("underrun_flag", 0, underrun_flag);
    strb(1);
    tick(4);
    chk_b("underrun_flag", 1, underrun_flag);
    chk_b("refill_req", 1, refill_req);
    {flags_clear, sw_stop} = 2'h3;
    play_mode = `DACWO_PLAY_SHOT;
    tick(1);
    {flags_clear, sw_stop} = 0;
    for (i = 0; i < 3; i++) put(24'($urandom));
    sw_start = 1;
    tick(1);
    sw_start = 0;
    strb(3);
    tick(4);
    chk_b("running", 0, running);
    chk_b("done", 1, waveform_complete_flag);
    chk_b("underrun_flag", 0, underrun_flag);
    play_mode = `DACWO_PLAY_REGEN;
    w = 24'($urandom);
    i_dacwo_host.send(w);
    i_dacwo_host.send(~w);
    for (i = 0; i < 5; i++) expq.push_back(i[0] ? ~w : w);
    sw_start = 1;
    tick(1);
    sw_start = 0;
    strb(5);
    tick(2); // let the last replayed word land before the reset
    chk_b("running", 1, running);
    sub_reset = 1;
    expq.push_back({2{`DACWO_ZERO_CODE}});
    tick(1);
    sub_reset = 0;
    play_mode = `DACWO_PLAY_CONT;
    internal_conversion_clock_select = `DACWO_SEL_INT;
    {base_sel_33, ext_start_en, ext_stop_en} = 3'h7;
    for (i = 0; i < 3; i++) put(24'($urandom));
    ext_trig = 1;
    tick(6);
    chk_b("running", 1, running);
    tick(120);
    ext_trig = 0;
    tick(4);
    ext_trig = 1;
    tick(6);
    chk_b("running", 0, running);
    internal_conversion_clock_select = `DACWO_SEL_EXT;
    ext_trig = 0;
    for (i = 0; i < 2; i++) put(24'($urandom));
    sw_start = 1;
    tick(1);
    sw_start = 0;
    for (i = 0; i < 2; i++) begin
      ext_trig = 1;
      tick(5);
      ext_trig = 0;
      tick(5);
    end
    chk_b("all loaded", 1, expq.size() == 0);
    conclude();
  end
endmodule // test_dual_dac_waveform_output
bind dacwo_top dacwo_props i_props (.clk(clk), .nrst(nrst),
  .sub_reset(sub_reset), .mode_buffered(mode_buffered),
  .single_wr0(single_wr0), .single_code0(single_code0),
  .single_wr1(single_wr1), .sw_start(sw_start), .sw_stop(sw_stop),
  .play_mode(play_mode), .flags_clear(flags_clear),
  .dac0_code_reg(dac0_code_reg), .dac1_code_reg(dac1_code_reg),
  .running(running), .refill_req(refill_req),
  .waveform_complete_flag(waveform_complete_flag),
  .underrun_flag(underrun_flag), .ai_sync_start(ai_sync_start), .irq(irq));
`default_nettype wire
